// [ppwt_cfg.svh]
`ifndef PPWT_CFG_SVH
`define PPWT_CFG_SVH

// Width of the measurement counter and its reload register.
`define PPWT_CNT_W        16

// Value the counter restarts from at each effective edge.
`define PPWT_CNT_ZERO     16'h0000

// Reset value of the captured measurement result.
`define PPWT_RELOAD_RST   16'h0000

// Count source select codes, high bit then low bit.
`define PPWT_SRC_UNDIV    2'h0
`define PPWT_SRC_DIV8     2'h1
`define PPWT_SRC_DIV32    2'h2
`define PPWT_SRC_SUB32    2'h3

// Effective edge select codes for the measurement input.
`define PPWT_MODE_FALL    2'h0
`define PPWT_MODE_RISE    2'h1
`define PPWT_MODE_WIDTH   2'h2

// Prescaler ratios for the divided count sources.
`define PPWT_DIV_FAST     8
`define PPWT_DIV_SLOW     32

`endif

// [ppwt_pkg.sv]
package ppwt_pkg;

  // Measurement phase: waiting for the first edge, one edge seen, results valid.
  typedef enum logic [1:0] {
    PPWT_ARMED,
    PPWT_FIRST,
    PPWT_GOOD
  } ppwt_phase_e;

  // Two-bit selector used for source and edge mode.
  typedef logic [1:0] ppwt_sel_t;

endpackage

// [ppwt_prescaler.sv]
`timescale 1ns/1ps
`include "ppwt_cfg.svh"

module ppwt_prescaler
  import ppwt_pkg::*;
#(
  parameter int DIV_FAST = `PPWT_DIV_FAST,
  parameter int DIV_SLOW = `PPWT_DIV_SLOW
) (
  // Clock and reset.
  input  wire logic      mclk,
  input  wire logic      rst_b,
  // Control.
  input  wire logic      run,
  input  wire ppwt_sel_t src_sel,
  input  wire logic      sub_tick,
  // Count enable pulse.
  output logic           tick
);

  localparam int FAST_W = $clog2(DIV_FAST);
  localparam int SLOW_W = $clog2(DIV_SLOW);

  // The fast tap is a low-bit slice of the slow counter, so both must be powers of two.
  if ((DIV_FAST < 2) || (DIV_SLOW <= DIV_FAST) || ((1 << FAST_W) != DIV_FAST) ||
      ((1 << SLOW_W) != DIV_SLOW)) begin : g_bad_div
    $error("ppwt_prescaler: divider ratios must be powers of two with fast below slow.");
  end

  logic [SLOW_W-1:0] main_cnt_r;  // Divides the system clock.
  logic [SLOW_W-1:0] sub_cnt_r;   // Divides the subclock ticks.

  // Named taps of the two dividers.
  wire main_fast_hit = &main_cnt_r[FAST_W-1:0];
  wire main_slow_hit = &main_cnt_r;
  wire sub_slow_hit  = sub_tick && (&sub_cnt_r);

  // Source multiplexer; a stopped timer sees no enable at all.
  wire tick_nxt = run && ((src_sel == `PPWT_SRC_UNDIV)  ||
                          ((src_sel == `PPWT_SRC_DIV8)  && main_fast_hit) ||
                          ((src_sel == `PPWT_SRC_DIV32) && main_slow_hit) ||
                          ((src_sel == `PPWT_SRC_SUB32) && sub_slow_hit));

  // The system divider restarts with the timer so the first period is a full one.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      main_cnt_r <= '0;
    end else begin
      main_cnt_r <= run ? main_cnt_r + SLOW_W'(1) : '0;
    end
  end

  // The subclock divider free-runs because the subclock is not ours to gate.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sub_cnt_r <= '0;
    end else if (sub_tick) begin
      sub_cnt_r <= sub_cnt_r + SLOW_W'(1);
    end
  end

  // Registered enable keeps the selector glitch free for the counter.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tick <= 1'b0;
    end else begin
      tick <= tick_nxt;
    end
  end

  // An undivided source enables every cycle after the timer has run one cycle.
  chk_source_undivided: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ($past(run) && ($past(src_sel) == `PPWT_SRC_UNDIV)) |-> tick)
    else $error("Undivided source did not enable the count.");

endmodule // ppwt_prescaler

// [ppwt_timer.sv]
`timescale 1ns/1ps
`include "ppwt_cfg.svh"

// Operation
// - Count source chosen from four clock rates
// - Edge captures count, restarts from zero
// - Counting only while count start is set
// - Edge raises request except the first one
// - Overflow raises request and sets flag
// - Mode write while running clears overflow flag
// - Timer read returns the captured result
// - Result undefined before the second edge
// - Timer writes are ignored in this mode
module ppwt_timer
  import ppwt_pkg::*;
#(
  parameter int CNT_W = `PPWT_CNT_W
) (
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // Mode register contents and its write strobe.
  input  wire logic             count_start,
  input  wire logic             source_select_low,
  input  wire logic             source_select_high,
  input  wire ppwt_sel_t        edge_mode,
  input  wire logic             mode_reg_write,
  // Timer register write strobe.
  input  wire logic             timer_write,
  // Subclock enable pulse, one cycle per subclock period.
  input  wire logic             subclock_tick,
  // External pulse to be measured.
  input  wire logic             measure_pulse_input,
  // Results and status.
  output logic [CNT_W-1:0]      timer_rdata,
  output logic                  result_valid,
  output logic                  irq_req,
  output logic                  overflow_flag
);

  // The capture path and the counter share one width; tiny counters make no sense.
  if (CNT_W < 2) begin : g_bad_width
    $error("ppwt_timer: counter width must be at least two bits.");
  end

  logic [CNT_W-1:0] count_r;      // Live up-counter.
  logic [CNT_W-1:0] count_nxt;    // Its next value.
  logic [CNT_W-1:0] reload_r;     // Captured measurement result.
  logic [CNT_W-1:0] reload_nxt;   // Its next value.
  logic             sync_1_r;     // First synchroniser stage.
  logic             sync_2_r;     // Second synchroniser stage.
  logic             sync_3_r;     // Previous synchronised level for edge detect.
  ppwt_phase_e      phase_r;      // Measurement phase.
  ppwt_phase_e      phase_nxt;    // Its next value.
  logic             count_tick;   // Count enable from the prescaler.
  logic             irq_nxt;      // Next interrupt request pulse.
  logic             ovf_nxt;      // Next overflow flag.

  // Source selector assembled from the two select bits.
  wire ppwt_sel_t src_sel = {source_select_high, source_select_low};

  // Prescaler turns the chosen rate into a one-cycle enable.
  ppwt_prescaler #(
    .DIV_FAST (`PPWT_DIV_FAST),
    .DIV_SLOW (`PPWT_DIV_SLOW)
  ) u_prescaler (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .run      (count_start),
    .src_sel  (src_sel),
    .sub_tick (subclock_tick),
    .tick     (count_tick)
  );

  // Two flops against metastability, a third to remember the previous level.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync_1_r <= 1'b0;
      sync_2_r <= 1'b0;
      sync_3_r <= 1'b0;
    end else begin
      sync_1_r <= measure_pulse_input;
      sync_2_r <= sync_1_r;
      sync_3_r <= sync_2_r;
    end
  end

  // Edge detect looks only at the settled stages.
  wire rise_seen = sync_2_r && !sync_3_r;
  wire fall_seen = !sync_2_r && sync_3_r;

  // Width mode measures between any two edges; the spare code behaves the same.
  wire eff_edge = (edge_mode == `PPWT_MODE_FALL) ? fall_seen :
                  (edge_mode == `PPWT_MODE_RISE) ? rise_seen :
                  (rise_seen || fall_seen);

  // An edge wins over a count tick in the same cycle, so the restart is clean.
  wire capture  = count_start && eff_edge;
  wire advance  = count_start && count_tick && !capture;
  wire at_top   = &count_r;
  wire ovf_evt  = advance && at_top;
  wire ovf_clr  = mode_reg_write && count_start;

  // Counter and capture register next values; timer writes play no part.
  assign count_nxt  = capture ? `PPWT_CNT_ZERO :
                      advance ? count_r + CNT_W'(1) : count_r;
  assign reload_nxt = capture ? count_r : reload_r;

  // The first edge after a start only opens the measurement.
  assign irq_nxt = (capture && (phase_r != PPWT_ARMED)) || ovf_evt;

  // Setting the flag wins over a clear in the same cycle, so no overflow is lost.
  assign ovf_nxt = ovf_evt ? 1'b1 : (ovf_clr ? 1'b0 : overflow_flag);

  // Phase tracks how many edges were captured since counting started.
  always_comb begin
    phase_nxt = phase_r;
    if (!count_start) begin
      phase_nxt = PPWT_ARMED;
    end else if (capture) begin
      unique case (phase_r)
        PPWT_ARMED: begin
          phase_nxt = PPWT_FIRST;
        end
        PPWT_FIRST: begin
          phase_nxt = PPWT_GOOD;
        end
        PPWT_GOOD: begin
          phase_nxt = PPWT_GOOD;
        end
      endcase
    end
  end

  // Counter state; a stopped timer simply holds its count.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count_r  <= `PPWT_CNT_ZERO;
      reload_r <= `PPWT_RELOAD_RST;
      phase_r  <= PPWT_ARMED;
    end else begin
      count_r  <= count_nxt;
      reload_r <= reload_nxt;
      phase_r  <= phase_nxt;
    end
  end

  // Output flops; the read port mirrors the capture register, never the live count.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      timer_rdata   <= `PPWT_RELOAD_RST;
      result_valid  <= 1'b0;
      irq_req       <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      timer_rdata   <= reload_nxt;
      result_valid  <= (phase_nxt == PPWT_GOOD);
      irq_req       <= irq_nxt;
      overflow_flag <= ovf_nxt;
    end
  end

  // A rising level on the pin as seen in two samples.
  sequence s_pin_rise;
    !measure_pulse_input ##1 measure_pulse_input;
  endsequence

  // One effective capture followed by a cycle still counting with no capture.
  sequence s_two_captures;
    capture ##1 (count_start && !capture)[*1] ##0 1;
  endsequence

  // A capture moves the count and zeroes the counter.
  chk_edge_capture: assert property (
    @(posedge mclk) disable iff (!rst_b)
    capture |=> ((reload_r == $past(count_r)) && (count_r == `PPWT_CNT_ZERO)))
    else $error("Edge did not capture and restart the counter.");

  // With the start flag clear nothing in the counter moves.
  chk_stop_holds: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !count_start |=> ($stable(count_r) && $stable(reload_r) && !irq_req))
    else $error("Stopped timer changed its count.");

  // The opening edge after a start raises no request.
  chk_first_silent: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (capture && (phase_r == PPWT_ARMED) && !ovf_evt) |=> !irq_req)
    else $error("First edge raised a request.");

  // Every later edge raises one request on the next cycle.
  chk_edge_request: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (capture && (phase_r != PPWT_ARMED)) |=> irq_req)
    else $error("Measured edge raised no request.");

  // Overflow raises the request and the flag together.
  chk_ovf_flag: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (count_start && count_tick && at_top && !eff_edge) |=>
      (irq_req && overflow_flag && (count_r == `PPWT_CNT_ZERO)))
    else $error("Overflow did not set request and flag.");

  // A mode write while running clears the flag unless a new overflow lands.
  chk_ovf_clear: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (mode_reg_write && count_start && !ovf_evt) |=> !overflow_flag)
    else $error("Mode write did not clear the overflow flag.");

  // The read value changes only one cycle after a capture.
  chk_read_result: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $changed(timer_rdata) |-> ($past(capture) && (timer_rdata == reload_r)))
    else $error("Read value changed without a capture.");

  // Valid appears only after two captures since the start.
  chk_valid_second: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $rose(result_valid) |-> ($past(capture) && ($past(phase_r) == PPWT_FIRST)))
    else $error("Result valid rose before the second edge.");

  // A timer write with no edge or tick leaves both registers alone.
  chk_write_ignored: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (timer_write && !capture && !advance) |=> ($stable(count_r) && $stable(reload_r)))
    else $error("Timer write altered the counter.");

  // A pin rise shows as an effective edge two cycles later in rising mode.
  chk_sync_edge: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_pin_rise |-> ##2 (eff_edge || (edge_mode == `PPWT_MODE_FALL)))
    else $error("Synchronised rising edge was missed.");

  // The second capture, followed by a counting cycle with no capture, ends with valid set.
  chk_two_edges: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (count_start && (phase_r == PPWT_FIRST)) ##0 s_two_captures |-> result_valid)
    else $error("Valid missing after the second edge.");

endmodule // ppwt_timer

// [ppwt_pulse_src.sv]
`timescale 1ns/1ps

// Far-side pulse source: a square wave whose phases are counted in mclk cycles.
module ppwt_pulse_src (
  // Clock and run control.
  input  wire logic        mclk,
  input  wire logic        en,
  // Lengths of the high and low phases.
  input  wire logic [15:0] hi,
  input  wire logic [15:0] lo,
  // Measured pin.
  output logic             pin
);
  int n;      // Cycles left in the current phase.
  logic go;   // Enable as it stood at the clock edge.

  // The level is held while disabled, so a paused source makes no stray edge.
  initial begin
    pin = 1'b0;
    n = 0;
  end

  // Phases alternate, changing just after the clock edge.
  // The enable is taken at the edge itself, so a bench change just after it cannot race.
  always @(posedge mclk) begin
    go = en;
    #1;
    if (go) begin
      if (n <= 1) begin
        pin = ~pin;
        n = pin ? int'(hi) : int'(lo);
      end else begin
        n = n - 1;
      end
    end
  end
endmodule // ppwt_pulse_src

// [ppwt_timer_tb_top.sv]
`timescale 1ns/1ps

module ppwt_timer_tb_top;
  import ppwt_pkg::*;
  logic        mclk, rst_b, run, mode_wr, tmr_wr, sub_tick, pin, src_en;
  ppwt_sel_t   src, mode;    // Source and edge selects.
  logic [15:0] hi, lo;       // Pulse phase lengths.
  logic [15:0] rdata, held;  // Result and a held copy.
  logic        valid, irq, ovf;
  int          failures, compares, sub_cnt;
  int          cyc;          // Cycle count seen by the reference model.
  int          stamps[$];    // Model: cycles of the last two effective edges while counting.
  logic        pin_q;        // Model: pin level at the previous edge.

  ppwt_timer DUT (.mclk(mclk), .rst_b(rst_b), .count_start(run),
    .source_select_low(src[0]), .source_select_high(src[1]), .edge_mode(mode),
    .mode_reg_write(mode_wr), .timer_write(tmr_wr), .subclock_tick(sub_tick),
    .measure_pulse_input(pin), .timer_rdata(rdata), .result_valid(valid),
    .irq_req(irq), .overflow_flag(ovf));
  ppwt_pulse_src far (.mclk(mclk), .en(src_en), .hi(hi), .lo(lo), .pin(pin));

  // Clock of 100 ns period.
  always #50 mclk = ~mclk;

  // Subclock pulse every second cycle, so its divided source is mclk/64.
  always @(posedge mclk) begin
    #1;
    sub_cnt++;
    sub_tick = (sub_cnt % 2 == 0);
  end

  // Reference model of edge selection: stamps each effective pin edge while the timer runs.
  always @(posedge mclk) begin
    cyc++;
    if (!run) begin
      stamps.delete();
    end else if ((pin !== pin_q) && (mode[1] || (pin === mode[0]))) begin
      stamps.push_back(cyc);
      if (stamps.size() > 2) void'(stamps.pop_front());
    end
    pin_q = pin;
  end

  // Divided sources have unknown prescaler phase, hence the tolerance.
  task automatic chk_val(string what, int expv, logic [15:0] got, int tol);
    compares++;
    if ((^got === 1'bx) || (int'(got) > expv + tol) || (int'(got) < expv - tol)) begin
      failures++;
      $display("[ERR] %s expected %0d seen %0d", what, expv, got);
    end
  endtask

  task automatic chk_bit(string what, logic expv, logic got);
    compares++;
    if (got !== expv) begin
      failures++;
      $display("[ERR] %s expected %b seen %b", what, expv, got);
    end
  endtask

  // Waits a bounded time for a request pulse; outputs are read once settled.
  task automatic wait_irq(int lim);
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while (irq !== 1'b1 && k < lim);
    chk_bit("irq", 1'b1, irq);
  endtask

  // One measurement run, then a stop with pulses still arriving.
  task automatic meas(ppwt_sel_t m, ppwt_sel_t s, int div);
    int per, ph, n, d;
    hi = 16'(div * (4 + $urandom % 6));
    lo = 16'(div * (4 + $urandom % 6));
    per = int'(hi) + int'(lo);
    n = 0;
    @(posedge mclk);
    #1;
    mode = m;
    src = s;
    src_en = 1'b1;
    run = 1'b1;
    wait_irq(4 * per + 20);
    chk_bit("valid", 1'b1, valid);
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      #1;
      tmr_wr = (i == 0);
      @(posedge mclk);
      #1;
      tmr_wr = 1'b0;
      wait_irq(per + 20);
      // In width mode a high pin means a low phase was just measured.
      ph = (m == 2'h2) ? (pin ? int'(lo) : int'(hi)) : per;
      chk_val("result", (div == 1) ? ph - 1 : ph / div, rdata, (div == 1) ? 0 : 1);
      d = (stamps.size() == 2) ? stamps[1] - stamps[0] : -1;
      chk_val("model result", (div == 1) ? d - 1 : d / div, rdata, (div == 1) ? 0 : 1);
    end
    @(posedge mclk);
    #1;
    run = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    held = rdata;
    tmr_wr = 1'b1;
    repeat (2 * per) begin
      @(posedge mclk);
      #1;
      tmr_wr = 1'b0;
      if (irq === 1'b1) n++;
    end
    chk_val("stopped irqs", 0, 16'(n), 0);
    chk_val("held result", int'(held), rdata, 0);
    chk_bit("valid stopped", 1'b0, valid);
    src_en = 1'b0;
    $display("meas mode %0d source %0d done", m, s);
  endtask

  task automatic tally_and_finish();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog sized for the overflow run plus the measurements.
  initial begin
    #(100 * 95000);
    failures++;
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    {run, mode_wr, tmr_wr, src_en} = 4'h0;
    src = 2'h0;
    mode = 2'h0;
    hi = 16'h0004;
    lo = 16'h0004;
    {failures, compares} = {32'h0, 32'h0};
    void'($urandom(9));
    repeat (5) @(posedge mclk);
    #1;
    chk_val("reset result", 0, rdata, 0);
    chk_bit("reset flags", 1'b0, valid | irq | ovf);
    rst_b = 1'b1;
    for (int m = 0; m < 3; m++) meas(2'(m), 2'h0, 1);
    meas(2'h0, 2'h1, 8);
    meas(2'h1, 2'h2, 32);
    meas(2'h0, 2'h3, 64);
    // Overflow with the pin quiet, then clear attempts stopped and running.
    @(posedge mclk);
    #1;
    src = 2'h0;
    run = 1'b1;
    wait_irq(70000);
    chk_bit("overflow set", 1'b1, ovf);
    run = 1'b0;
    mode_wr = 1'b1;
    @(posedge mclk);
    #1;
    chk_bit("overflow kept", 1'b1, ovf);
    run = 1'b1;
    mode_wr = 1'b0;
    @(posedge mclk);
    #1;
    mode_wr = 1'b1;
    @(posedge mclk);
    #1;
    mode_wr = 1'b0;
    chk_bit("overflow cleared", 1'b0, ovf);
    $display("overflow done");
    tally_and_finish();
  end
endmodule // ppwt_timer_tb_top
